// [rtl/ais_sequencer.sv]
`timescale 1ns/1ps
`include "ais_consts.svh"

module ais_sequencer #(
  parameter logic [21:0] CAL_FULL_CYC = `AIS_CAL_FULL_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cfg_start,
  input wire logic cfg_cal_short,
  input wire logic cfg_cal_full,
  input wire logic cfg_reset,
  input wire logic [15:0] timer_preset,
  input wire logic imem_wr,
  input wire logic [2:0] imem_addr,
  input wire ais_pkg::ais_word_t imem_data,
  input wire logic [15:0] sample_code,
  output logic [2:0] instr_counter,
  output logic seq_busy,
  output logic seq_paused,
  output logic cal_done,
  output logic [15:0] result_code,
  output logic result_valid
);
  import ais_pkg::*;

  ais_regs_t s;
  ais_regs_t next_s;
  logic [15:0] sat_code;

  // ****************************************
  // cycle count per state
  // ****************************************
  // returns the load value, cycles minus one, so a state ends at zero
  function automatic logic [21:0] load_for(ais_state_t t, ais_word_t w, logic full,
                                           logic [15:0] tmr, logic [21:0] full_cyc);
    logic [21:0] cyc;
    logic fast;
    cyc = `AIS_ONE_CYC;
    fast = w[`AIS_NINE_BIT] | w[`AIS_WD_BIT];
    unique case (t)
      AIS_FETCH: cyc = `AIS_ONE_CYC;
      AIS_CHECK: cyc = `AIS_ONE_CYC;
      AIS_CAL: cyc = full ? full_cyc : `AIS_CAL_SHORT_CYC;
      AIS_TIMER_WAIT_STATE: cyc = {1'b0, tmr, 5'h00} + `AIS_TMR_ADD;
      AIS_ACQ: cyc = (fast ? `AIS_ACQ9_BASE : `AIS_ACQ13_BASE)
                     + {17'h0, w[`AIS_DLY_MSB:`AIS_DLY_LSB], 1'b0};
      AIS_CMP1: cyc = `AIS_CMP1_CYC;
      AIS_LIM2: cyc = `AIS_LIM2_CYC;
      AIS_CONV: cyc = w[`AIS_WD_BIT] ? `AIS_CONVWD_CYC
                      : (w[`AIS_NINE_BIT] ? `AIS_CONV9_CYC : `AIS_CONV13_CYC);
    endcase
    return cyc - `AIS_ONE_CYC;
  endfunction

  // ****************************************
  // result clamp
  // ****************************************
  ais_saturate u_sat (
    .raw(sample_code),
    .nine_bit(s.word[`AIS_NINE_BIT]),
    .sat(sat_code)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.cal_done = 1'b0;
    next_s.result_valid = 1'b0;
    // host writes go straight into the instruction memory
    if (imem_wr) begin
      next_s.imem[imem_addr] = imem_data;
    end
    if (s.cnt != 22'h0) begin
      next_s.cnt = s.cnt - 22'h1;
    end else begin
      unique case (s.st)
        AIS_FETCH: begin
          next_s.word = s.imem[s.ctr];
          next_s.st = AIS_CHECK;
          next_s.cnt = 22'h0;
        end
        AIS_CHECK: begin
          if (!cfg_start) begin
            // rest; a pause already honoured is not honoured again
            if (s.paused) begin
              next_s.served = 1'b1;
            end
            next_s.paused = 1'b0;
          end else if (s.word[`AIS_PAUSE_BIT] && !s.served) begin
            next_s.paused = 1'b1;
          end else begin
            next_s.served = 1'b0;
            next_s.paused = 1'b0;
            if (cfg_cal_short || cfg_cal_full) begin
              next_s.st = AIS_CAL;
            end else if (s.word[`AIS_TMR_EN_BIT]) begin
              next_s.st = AIS_TIMER_WAIT_STATE;
            end else begin
              next_s.st = AIS_ACQ;
            end
            next_s.cnt = load_for(next_s.st, s.word, cfg_cal_full, timer_preset, CAL_FULL_CYC);
          end
        end
        AIS_CAL: begin
          next_s.cal_done = 1'b1;
          next_s.st = s.word[`AIS_TMR_EN_BIT] ? AIS_TIMER_WAIT_STATE : AIS_ACQ;
          next_s.cnt = load_for(next_s.st, s.word, cfg_cal_full, timer_preset, CAL_FULL_CYC);
        end
        AIS_TIMER_WAIT_STATE: begin
          next_s.st = AIS_ACQ;
          next_s.cnt = load_for(AIS_ACQ, s.word, cfg_cal_full, timer_preset, CAL_FULL_CYC);
        end
        AIS_ACQ: begin
          // comparisons exist only in watchdog mode
          next_s.st = s.word[`AIS_WD_BIT] ? AIS_CMP1 : AIS_CONV;
          next_s.cnt = load_for(next_s.st, s.word, cfg_cal_full, timer_preset, CAL_FULL_CYC);
        end
        AIS_CMP1: begin
          next_s.st = AIS_LIM2;
          next_s.cnt = load_for(AIS_LIM2, s.word, cfg_cal_full, timer_preset, CAL_FULL_CYC);
        end
        AIS_LIM2: begin
          next_s.st = AIS_CONV;
          next_s.cnt = load_for(AIS_CONV, s.word, cfg_cal_full, timer_preset, CAL_FULL_CYC);
        end
        AIS_CONV: begin
          if (!s.word[`AIS_WD_BIT]) begin
            next_s.result = sat_code;
            next_s.result_valid = 1'b1;
          end
          if (s.word[`AIS_LOOP_BIT]) begin
            next_s.ctr = `AIS_CTR_RESET;
          end else begin
            next_s.ctr = s.ctr + 3'h1;
          end
          next_s.st = AIS_FETCH;
          next_s.cnt = 22'h0;
        end
      endcase
    end
    // reset bit aborts the instruction and restarts from entry zero
    if (cfg_reset) begin
      next_s.st = AIS_FETCH;
      next_s.ctr = `AIS_CTR_RESET;
      next_s.cnt = 22'h0;
      next_s.paused = 1'b0;
      next_s.served = 1'b0;
    end
    // busy kept as a flop field so the output is never decoded
    next_s.busy = (next_s.st != AIS_CHECK);
  end

  // ****************************************
  // state registers
  // ****************************************
  // all-zero reset lands in fetch with counter at entry zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // status outputs are flop fields, never decoded
  assign instr_counter = s.ctr;
  assign seq_busy = s.busy;
  assign seq_paused = s.paused;
  assign cal_done = s.cal_done;
  assign result_code = s.result;
  assign result_valid = s.result_valid;

  // ****************************************
  // checks
  // ****************************************
  logic [15:0] fetch_view;
  logic [21:0] tmr_load;
  logic conv_end;
  assign fetch_view = s.imem[s.ctr];
  assign tmr_load = {1'b0, timer_preset, 5'h00} + `AIS_TMR_ADD - 22'h1;
  assign conv_end = (s.st == AIS_CONV) && (s.cnt == 22'h0);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || cfg_reset);

  AST_FETCH_WORD: assert property ((s.st == AIS_FETCH) |=> (s.word == $past(fetch_view))
                                   && (s.st == AIS_CHECK))
    else $error("fetch did not load the indexed word in one cycle");
  AST_LOOP_CLEAR: assert property ((conv_end && s.word[`AIS_LOOP_BIT]) |=> (instr_counter == 3'h0))
    else $error("loop bit did not clear the instruction counter");
  AST_STEP: assert property ((conv_end && !s.word[`AIS_LOOP_BIT])
                             |=> (instr_counter == 3'($past(instr_counter) + 3'h1)))
    else $error("instruction counter did not step");
  AST_RESET_BIT: assert property (@(posedge clk) disable iff (sys_rst)
                                  cfg_reset |=> (instr_counter == 3'h0) && (s.st == AIS_FETCH))
    else $error("reset bit did not restart the sequencer");
  AST_REST: assert property ((s.st == AIS_CHECK && !cfg_start) |=> (s.st == AIS_CHECK))
    else $error("sequencer left check while stopped");
  AST_CAL_SHORT: assert property (($rose(s.st == AIS_CAL) && !$past(cfg_cal_full))
                                  |-> (s.cnt == `AIS_CAL_SHORT_CYC - 22'h1))
    else $error("short calibration length wrong");
  AST_TIMER_LEN: assert property ($rose(s.st == AIS_TIMER_WAIT_STATE)
                                  |-> (s.cnt == $past(tmr_load)) && s.word[`AIS_TMR_EN_BIT])
    else $error("timer state entered wrongly or with wrong length");
  AST_ACQ_LEN: assert property ($rose(s.st == AIS_ACQ) |-> (s.cnt == 22'(((s.word[`AIS_NINE_BIT]
                                 || s.word[`AIS_WD_BIT]) ? 1 : 8) + 2 * s.word[`AIS_DLY_MSB:`AIS_DLY_LSB])))
    else $error("acquisition length wrong");
  AST_CMP1_LEN: assert property ($rose(s.st == AIS_CMP1) |-> (s.st == AIS_CMP1)[*5] ##1 (s.st == AIS_LIM2))
    else $error("first comparison not five cycles");
  AST_LIM2_LEN: assert property ((s.st == AIS_LIM2) |=> (s.st == AIS_CONV))
    else $error("second limit fetch not one cycle");
  AST_CONV_WD: assert property (($rose(s.st == AIS_CONV) && s.word[`AIS_WD_BIT])
                                |-> (s.st == AIS_CONV)[*5] ##1 (s.st == AIS_FETCH))
    else $error("watchdog compare not five cycles");
  AST_SKIP_CMP: assert property ((s.st == AIS_ACQ && s.cnt == 22'h0 && !s.word[`AIS_WD_BIT])
                                 |=> (s.st == AIS_CONV))
    else $error("comparison states not skipped");
  AST_CLAMP: assert property (result_valid |-> ($signed(result_code) <= $signed(`AIS_MAX13))
                              && ($signed(result_code) >= $signed(`AIS_MIN13)))
    else $error("result outside clamp range");
  AST_CLAMP9: assert property ((result_valid && s.word[`AIS_NINE_BIT])
                               |-> ($signed(result_code) <= $signed(`AIS_MAX9))
                               && ($signed(result_code) >= $signed(`AIS_MIN9)))
    else $error("reduced resolution result outside clamp range");
  AST_REFETCH: assert property (conv_end |=> (s.st == AIS_FETCH) ##1 (s.st == AIS_CHECK))
    else $error("no fetch after conversion");

  COV_WD: cover property ($rose(s.st == AIS_CMP1));
  COV_LOOP: cover property (conv_end && s.word[`AIS_LOOP_BIT]);
  COV_WRAP: cover property (conv_end && instr_counter == 3'h7 && !s.word[`AIS_LOOP_BIT]);
  COV_PAUSE: cover property ($rose(seq_paused));
endmodule

// [rtl/ais_consts.svh]
`ifndef AIS_CONSTS_SVH
`define AIS_CONSTS_SVH

// ****************************************
// instruction word fields
// ****************************************
`define AIS_PAUSE_BIT 0
`define AIS_LOOP_BIT 1
`define AIS_TMR_EN_BIT 9
`define AIS_NINE_BIT 10
`define AIS_WD_BIT 11
`define AIS_DLY_MSB 15
`define AIS_DLY_LSB 12

// ****************************************
// reset values and timing counts
// ****************************************
`define AIS_CTR_RESET 3'h0
`define AIS_CAL_SHORT_CYC 22'h4c
`define AIS_CAL_FULL_CYC 22'h1350
`define AIS_TMR_ADD 22'h2
`define AIS_ACQ13_BASE 22'h9
`define AIS_ACQ9_BASE 22'h2
`define AIS_CMP1_CYC 22'h5
`define AIS_LIM2_CYC 22'h1
`define AIS_CONV13_CYC 22'h2c
`define AIS_CONV9_CYC 22'h15
`define AIS_CONVWD_CYC 22'h5
`define AIS_ONE_CYC 22'h1

// ****************************************
// result limits
// ****************************************
`define AIS_MAX13 16'h0fff
`define AIS_MIN13 16'hf000
`define AIS_MAX9 16'h00ff
`define AIS_MIN9 16'hff00

`endif

// [rtl/ais_pkg.sv]
package ais_pkg;

  typedef enum logic [2:0] {
    AIS_FETCH,
    AIS_CHECK,
    AIS_CAL,
    AIS_TIMER_WAIT_STATE,
    AIS_ACQ,
    AIS_CMP1,
    AIS_LIM2,
    AIS_CONV
  } ais_state_t;

  typedef logic [15:0] ais_word_t;

  typedef struct packed {
    ais_word_t [7:0] imem;
    ais_state_t st;
    logic [21:0] cnt;
    logic [2:0] ctr;
    ais_word_t word;
    logic paused;
    logic served;
    logic cal_done;
    logic [15:0] result;
    logic result_valid;
    logic busy;
  } ais_regs_t;

endpackage

// [rtl/ais_saturate.sv]
`timescale 1ns/1ps
`include "ais_consts.svh"

// ****************************************
// result clamp to the selected resolution
// ****************************************
module ais_saturate (
  input wire logic [15:0] raw,
  input wire logic nine_bit,
  output logic [15:0] sat
);
  logic signed [15:0] s_raw;
  logic signed [15:0] hi;
  logic signed [15:0] lo;

  // limits depend on mode; comparison is signed
  always_comb begin
    s_raw = signed'(raw);
    hi = nine_bit ? signed'(`AIS_MAX9) : signed'(`AIS_MAX13);
    lo = nine_bit ? signed'(`AIS_MIN9) : signed'(`AIS_MIN13);
    if (s_raw > hi) begin
      sat = hi;
    end else if (s_raw < lo) begin
      sat = lo;
    end else begin
      sat = raw;
    end
  end
endmodule

// [test/ais_host_model.sv]
`timescale 1ns/1ps

// ****************************************
// host side: writes a program into the instruction memory
// ****************************************
module ais_host_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic go,
  input wire logic [3:0] n,
  input wire ais_pkg::ais_word_t [7:0] prog,
  output logic imem_wr,
  output logic [2:0] imem_addr,
  output ais_pkg::ais_word_t imem_data,
  output logic busy
);
  import ais_pkg::*;
  logic [3:0] idx;
  // one word per cycle; data toggles when idle so stale values never look valid
  always @(posedge clk) begin
    if (sys_rst) begin
      imem_wr <= 1'b0;
      imem_addr <= 3'h0;
      imem_data <= 16'h0;
      busy <= 1'b0;
      idx <= 4'h0;
    end else if (go && !busy) begin
      busy <= 1'b1;
      idx <= 4'h0;
    end else if (busy && idx < n) begin
      imem_wr <= 1'b1;
      imem_addr <= idx[2:0];
      // short programs end on a looping entry
      imem_data <= (idx == n - 4'h1 && n < 4'h8) ? (prog[idx[2:0]] | 16'h0002) : prog[idx[2:0]];
      idx <= idx + 4'h1;
    end else begin
      imem_wr <= 1'b0;
      busy <= 1'b0;
      imem_data <= ~imem_data;
    end
  end
endmodule

// [test/ais_sequencer_tb.sv]
`timescale 1ns/1ps

module ais_sequencer_tb;
  import ais_pkg::*;
  typedef struct {
    ais_word_t w;
    logic [15:0] t;
    logic cs;
    logic cf;
    logic [15:0] smp;
    logic [15:0] res;
    int cyc;
  } ais_row_t;
  logic clk = 1'b0, sys_rst = 1'b1, cfg_start = 1'b0, cfg_cal_short = 1'b0, cfg_cal_full = 1'b0;
  logic cfg_reset = 1'b0, go = 1'b0, imem_wr, busy, seq_busy, seq_paused, cal_done, result_valid;
  logic [15:0] timer_preset = 16'h0, sample_code = 16'h0, result_code;
  logic [3:0] n = 4'h1;
  logic [2:0] imem_addr, instr_counter;
  ais_word_t imem_data;
  ais_word_t [7:0] prog = '0;
  int num_errors = 0, checks_done = 0, cycles = 0, cal_seen = 0, c, k;
  // cycle figures worked out by hand; full calibration shortened to 20
  ais_row_t rows [8] = '{
    '{16'h0000, 16'h0, 1'b0, 1'b0, 16'h2000, 16'h0fff, 55},
    '{16'hf000, 16'h0, 1'b0, 1'b0, 16'h0123, 16'h0123, 85},
    '{16'h3400, 16'h0, 1'b0, 1'b0, 16'hfe00, 16'hff00, 31},
    '{16'h1800, 16'h0, 1'b0, 1'b0, 16'h0000, 16'h0000, 17},
    '{16'h0200, 16'h2, 1'b0, 1'b0, 16'h8000, 16'hf000, 121},
    '{16'h0200, 16'h0, 1'b0, 1'b0, 16'h0001, 16'h0001, 57},
    '{16'h0000, 16'h0, 1'b1, 1'b0, 16'h00ff, 16'h00ff, 131},
    '{16'h0000, 16'h0, 1'b1, 1'b1, 16'hff00, 16'hff00, 75}};

  always #5 clk = ~clk;

  ais_sequencer #(.CAL_FULL_CYC(22'h14)) dut (.clk(clk), .sys_rst(sys_rst), .cfg_start(cfg_start),
    .cfg_cal_short(cfg_cal_short), .cfg_cal_full(cfg_cal_full), .cfg_reset(cfg_reset),
    .timer_preset(timer_preset), .imem_wr(imem_wr), .imem_addr(imem_addr), .imem_data(imem_data),
    .sample_code(sample_code), .instr_counter(instr_counter), .seq_busy(seq_busy), .seq_paused(seq_paused),
    .cal_done(cal_done), .result_code(result_code), .result_valid(result_valid));
  ais_host_model host (.clk(clk), .sys_rst(sys_rst), .go(go), .n(n), .prog(prog), .imem_wr(imem_wr),
    .imem_addr(imem_addr), .imem_data(imem_data), .busy(busy));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_cnt(input string nm, input int e, input int g);
    checks_done++;
    if (g != e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic stop_test();
    if (num_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clk) sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
  endtask
  // program, then restart at entry 0 so the first fetch sees the new words
  task automatic load(input ais_word_t w, input logic [3:0] cnt);
    prog = {8{w}};
    n = cnt;
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    k = 0;
    do begin @(posedge clk); k++; end while (busy && k < 20);
    cfg_reset <= 1'b1;
    @(posedge clk) cfg_reset <= 1'b0;
  endtask
  // cycles until the counter moves; bounded so a stuck counter shows as a wrong count
  task automatic wait_chg(output int cnt);
    logic [2:0] p;
    p = instr_counter;
    cnt = 0;
    do begin
      @(posedge clk);
      #1;
      cnt++;
      if (cal_done === 1'b1) cal_seen++;
    end while (instr_counter === p && cnt < 3000);
  endtask

  // runaway guard well above the longest expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      stop_test();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    do_reset();
    // table: two identical entries, second one loops
    foreach (rows[i]) begin
      do_reset();
      load(rows[i].w, 4'h2);
      timer_preset <= rows[i].t;
      sample_code <= rows[i].smp;
      cfg_cal_short <= rows[i].cs;
      cfg_cal_full <= rows[i].cf;
      cfg_start <= 1'b1;
      wait_chg(c);
      chk("ctr step", 16'h1, {13'h0, instr_counter});
      cal_seen = 0;
      wait_chg(c);
      chk_cnt("instr cycles", rows[i].cyc, c);
      chk("ctr loop", 16'h0, {13'h0, instr_counter});
      chk_cnt("cal pulses", (rows[i].cs | rows[i].cf) ? 1 : 0, cal_seen);
      if (!rows[i].w[11]) begin
        chk("valid", 16'h1, {15'h0, result_valid});
        chk("result", rows[i].res, result_code);
      end
      @(posedge clk) cfg_start <= 1'b0;
      cfg_cal_short <= 1'b0;
      cfg_cal_full <= 1'b0;
    end
    // start low rests in check; then eight entries wrap with no loop bit
    do_reset();
    load(16'h0000, 4'h8);
    repeat (20) @(posedge clk);
    #1;
    chk("rest ctr", 16'h0, {13'h0, instr_counter});
    chk("rest busy", 16'h0, {15'h0, seq_busy});
    cfg_start <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      wait_chg(c);
      chk("wrap ctr", 16'((i + 1) % 8), {13'h0, instr_counter});
    end
    // reset bit in mid-run restarts at entry 0
    do wait_chg(c); while (instr_counter !== 3'h3 && c < 3000);
    @(posedge clk) cfg_reset <= 1'b1;
    @(posedge clk) cfg_reset <= 1'b0;
    #1;
    chk("reset bit", 16'h0, {13'h0, instr_counter});
    wait_chg(c);
    chk_cnt("restart cycles", 55, c);
    // pause holds before running, resumes after start toggles
    @(posedge clk) cfg_start <= 1'b0;
    do_reset();
    load(16'h0001, 4'h1);
    cfg_start <= 1'b1;
    k = 0;
    do begin @(posedge clk); #1; k++; end while (seq_paused !== 1'b1 && k < 20);
    chk("paused", 16'h1, {15'h0, seq_paused});
    @(posedge clk) cfg_start <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("unpaused", 16'h0, {15'h0, seq_paused});
    @(posedge clk) cfg_start <= 1'b1;
    k = 0;
    do begin @(posedge clk); #1; k++; end while (result_valid !== 1'b1 && k < 200);
    chk("resumed", 16'h1, {15'h0, result_valid});
    stop_test();
  end
endmodule
